// File: verilog/pdtp_core.sv
// Inbound PCI-to-system translation with channel and stream prefetch.
// Assumes PCI controller side and memory fabric are request/valid logic
// on ref_clk; the channel builder writes one context word per build.
//
// Function
// - Top ten PCI address bits pick channel; low 22 bits are offset.
// - Channels 1008 to 1023 never translate PCI reads as DMA channels; a build prefetch still translates.
// - Each channel's own translate-enable picks physical or table mode.
// - Physical mode joins 18-bit base with 22-bit offset.
// - Channel 1023 reads reach the whole context SRAM, not memory; its build prefetch goes to memory.
// - Table mode maps 4 KB pages via the channel's table base.
// - Page table holds 1024 entries of 32 bits, four kilobytes.
// - Entries use the data-mover format, low 28 bits page number.
// - Prefetched data dropped on channel rebuild; stream line also on channel switch.
// - Reads served from channel buffer first, then stream buffer.
// - One start-up prefetch buffer per usable channel in external SRAM.
// - One streaming buffer holds the controller's current stream.
// - Channel buffer depth covers local latency, stream remote latency.
// - Prefetch-enable set fetches channel data at build time, for a build written while idle.
// - Refetch set only records the left channel in fill_chan; no refill is issued.
// - Each line delivered, except from channel 1023, schedules one new stream prefetch.
// - On a miss, prefetch repeatedly at programmed interval until hit.
`timescale 1ns/1ps
`default_nettype none
module pdtp_core
    import pdtp_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,
    // PCI read request from the controller
    input  wire logic                      pci_req,
    input  wire logic [PDTP_PCI_AW-1:0]    pci_addr,
    output logic                           pci_valid,
    output logic [PDTP_LINE_W-1:0]         pci_data,
    output logic                           pci_busy,
    output logic                           pci_nodma,
    // Channel builder write
    input  wire logic                      build_we,
    input  wire logic [PDTP_CHAN_W-1:0]    build_chan,
    input  wire logic [PDTP_CTX_W-1:0]     build_ctx,
    // Memory fabric read port
    output logic                           mem_req,
    output logic [PDTP_SYS_AW-1:0]         mem_addr,
    output logic                           mem_sram,
    input  wire logic                      mem_valid,
    input  wire logic [PDTP_LINE_W-1:0]    mem_data,
    // External prefetch SRAM: one line per channel
    output logic                           pf_we,
    output logic [PDTP_CHAN_W-1:0]         pf_addr,
    output logic [PDTP_LINE_W-1:0]         pf_wdata,
    input  wire logic [PDTP_LINE_W-1:0]    pf_rdata,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_we,
    input  wire logic                      reg_re,
    output logic [31:0]                    reg_rdata
);
    import pdtp_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pdtp_state_e             st;
        logic [PDTP_PCI_AW-1:0]  addr;
        logic [PDTP_CTX_W-1:0]   ctx;
        logic [PDTP_CHAN_W-1:0]  cur_chan;
        logic                    cur_vld;
        logic [PDTP_OFS_W-1:0]   stop_ofs;
        logic [PDTP_CHANS-1:0]   pf_full;
        logic [PDTP_SYS_AW-1:0]  strm_addr;
        logic [PDTP_LINE_W-1:0]  strm_data;    // One line deep per stream
        logic                    strm_vld;
        logic                    strm_pend;
        logic                    stall;
        logic [15:0]             stall_cnt;
        logic [15:0]             stall_ivl;
        logic                    pf_rd;
        logic                    fill_pend;
        logic [PDTP_CHAN_W-1:0]  fill_chan;
        logic                    pci_valid;
        logic [PDTP_LINE_W-1:0]  pci_data;
        logic                    pci_busy;
        logic                    pci_nodma;
        logic                    mem_req;
        logic [PDTP_SYS_AW-1:0]  mem_addr;
        logic                    mem_sram;
        logic                    pf_we;
        logic [PDTP_CHAN_W-1:0]  pf_addr;
        logic [PDTP_LINE_W-1:0]  pf_wdata;
        logic [31:0]             reg_rdata;
    } pdtp_s;

    pdtp_s s_q;
    pdtp_s s_d;

    pdtp_ctx_if ctx_bus ();

    pdtp_ctx_mem u_ctx (
        .ref_clk (ref_clk),
        .port    (ctx_bus)
    );

    // Context memory: builder write wins the port, else look up channel
    assign ctx_bus.we    = build_we;
    assign ctx_bus.addr  = build_we ? build_chan : pci_addr[PDTP_PCI_AW-1 -: PDTP_CHAN_W];
    assign ctx_bus.wdata = build_ctx;

    logic [PDTP_CHAN_W-1:0]  chan;
    logic [PDTP_OFS_W-1:0]   ofs;
    logic                    xl;
    logic [PDTP_SYS_AW-1:0]  phys_a;
    logic [PDTP_SYS_AW-1:0]  ent_a;
    logic [PDTP_SYS_AW-1:0]  pg_a;

    // Address field split and the two translation forms
    always_comb
    begin
        chan   = s_q.addr[PDTP_PCI_AW-1 -: PDTP_CHAN_W];
        ofs    = s_q.addr[PDTP_OFS_W-1:0];
        xl     = s_q.ctx[PDTP_CTX_XLATE];
        phys_a = {s_q.ctx[PDTP_CTX_BASE_LO +: PDTP_PBASE_W], ofs};
        // Table base names a 4 KB page; entry offset is 4 * page number
        ent_a  = {s_q.ctx[PDTP_CTX_BASE_LO +: PDTP_SPG_W],
                  s_q.addr[PDTP_PG_OFS_W +: PDTP_PG_NUM_W],
                  PDTP_ENTRY_SHIFT_ZERO};
        // Entry low 28 bits give the system page, joined with page offset
        pg_a   = {mem_data[PDTP_SPG_W-1:0],
                  s_q.addr[PDTP_PG_OFS_W-1:0]};
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d           = s_q;
        s_d.pci_valid = 1'b0;
        s_d.mem_req   = 1'b0;
        s_d.pf_we     = 1'b0;
        s_d.pf_rd     = 1'b0;
        s_d.reg_rdata = 32'h0000_0000;

        // Register port: read data lands one cycle after the strobe
        if (reg_we && reg_addr == PDTP_REG_STALL_IVL)
        begin
            s_d.stall_ivl = reg_wdata[15:0];
        end
        if (reg_re)
        begin
            case (reg_addr)
                PDTP_REG_STALL_IVL: s_d.reg_rdata = {16'h0000, s_q.stall_ivl};
                PDTP_REG_STATUS:    s_d.reg_rdata = {26'h0000000, s_q.st, s_q.stall,
                                                     s_q.strm_vld, s_q.cur_vld};
                PDTP_REG_CUR_CHAN:  s_d.reg_rdata = {22'h000000, s_q.cur_chan};
                default:            s_d.reg_rdata = 32'h0000_0000;
            endcase
        end

        case (s_q.st)
            PDTP_IDLE:
            begin
                if (build_we)
                begin
                    // Context word taken straight from the builder for build prefetch
                    s_d.fill_chan = build_chan;
                    s_d.ctx       = build_ctx;
                    s_d.addr      = {build_chan, 22'h000000};
                    s_d.st        = build_ctx[PDTP_CTX_PFEN] ? PDTP_BUILD : PDTP_IDLE;
                end
                else if (pci_req)
                begin
                    s_d.addr     = pci_addr;
                    s_d.pci_busy = 1'b1;
                    s_d.st       = PDTP_CTX;
                end
            end
            PDTP_BUILD:
            begin
                // Held physical or first page fetch into the channel slot
                s_d.fill_pend = 1'b1;
                s_d.st        = PDTP_ROUTE;
            end
            PDTP_CTX:
            begin
                s_d.ctx = ctx_bus.rdata;
                s_d.st  = PDTP_ROUTE;
            end
            PDTP_ROUTE:
            begin
                if (!s_q.fill_pend && chan == PDTP_SRAM_CHAN)
                begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_sram = 1'b1;
                    s_d.pci_nodma = 1'b0;
                    s_d.mem_addr = {18'h00000, ofs};
                    s_d.st       = PDTP_FETCH;
                end
                else if (!s_q.fill_pend && chan >= PDTP_RSVD_FIRST)
                begin
                    s_d.pci_nodma = 1'b1;
                    s_d.pci_busy  = 1'b0;
                    s_d.st        = PDTP_IDLE;
                end
                else
                begin
                    s_d.pci_nodma = 1'b0;
                    // Leaving a channel: drop its stream line and stall state
                    if (!s_q.fill_pend && s_q.cur_vld && s_q.cur_chan != chan)
                    begin
                        s_d.strm_vld = 1'b0;
                        s_d.stall    = 1'b0;
                    end
                    if (!s_q.fill_pend)
                    begin
                        s_d.cur_chan = chan;
                        s_d.cur_vld  = 1'b1;
                        s_d.pf_addr  = chan;
                        s_d.pf_rd    = 1'b1;
                    end
                    s_d.mem_sram = 1'b0;
                    if (xl)
                    begin
                        s_d.mem_req  = 1'b1;
                        s_d.mem_addr = ent_a;
                        s_d.st       = PDTP_ENTRY;
                    end
                    else
                    begin
                        s_d.mem_req  = 1'b1;
                        s_d.mem_addr = phys_a;
                        s_d.st       = PDTP_FETCH;
                    end
                end
            end
            PDTP_ENTRY:
            begin
                // PCI read stays stalled until the entry returns
                if (mem_valid)
                begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_addr = pg_a;
                    s_d.st       = PDTP_FETCH;
                end
            end
            PDTP_FETCH:
            begin
                if (s_q.fill_pend)
                begin
                    // Build-time fill of the channel buffer
                    if (mem_valid)
                    begin
                        s_d.pf_we                = 1'b1;
                        s_d.pf_addr              = s_q.fill_chan;
                        s_d.pf_wdata             = mem_data;
                        s_d.pf_full[s_q.fill_chan] = 1'b1;
                        s_d.fill_pend            = 1'b0;
                        s_d.st                   = PDTP_IDLE;
                    end
                end
                else if (s_q.pf_rd && !s_q.mem_sram && s_q.pf_full[chan])
                begin
                    // Channel buffer line stands one cycle after its address
                    s_d.stall = 1'b0;
                end
                else if (!s_q.mem_sram && s_q.pf_full[chan])
                begin
                    // Channel buffer answers first, then is consumed
                    s_d.pci_valid     = 1'b1;
                    s_d.pci_data      = pf_rdata;
                    s_d.pf_full[chan] = 1'b0;
                    s_d.stop_ofs      = ofs + PDTP_LINE_BYTES;
                    s_d.strm_addr     = s_q.mem_addr + {18'h00000, PDTP_LINE_BYTES};
                    s_d.strm_pend     = 1'b1;
                    s_d.pci_busy      = 1'b0;
                    s_d.st            = PDTP_IDLE;
                end
                else if (!s_q.mem_sram && s_q.strm_vld && s_q.strm_addr == s_q.mem_addr)
                begin
                    s_d.pci_valid = 1'b1;
                    s_d.pci_data  = s_q.strm_data;
                    s_d.strm_vld  = 1'b0;
                    s_d.stop_ofs  = ofs + PDTP_LINE_BYTES;
                    s_d.strm_addr = s_q.strm_addr + {18'h00000, PDTP_LINE_BYTES};
                    s_d.strm_pend = 1'b1;
                    s_d.stall     = 1'b0;
                    s_d.pci_busy  = 1'b0;
                    s_d.st        = PDTP_IDLE;
                end
                else if (mem_valid)
                begin
                    // Demand line arrived; stall prefetching ends
                    s_d.pci_valid = 1'b1;
                    s_d.pci_data  = mem_data;
                    s_d.stall     = 1'b0;
                    s_d.stop_ofs  = ofs + PDTP_LINE_BYTES;
                    s_d.strm_addr = s_q.mem_addr + {18'h00000, PDTP_LINE_BYTES};
                    s_d.strm_pend = !s_q.mem_sram;
                    s_d.pci_busy  = 1'b0;
                    s_d.st        = PDTP_IDLE;
                end
                else
                begin
                    // Miss: keep reissuing at the programmed interval
                    s_d.stall = 1'b1;
                    if (s_q.stall_cnt >= s_q.stall_ivl)
                    begin
                        s_d.mem_req   = 1'b1;
                        s_d.stall_cnt = 16'h0000;
                    end
                    else
                    begin
                        s_d.stall_cnt = s_q.stall_cnt + 16'h0001;
                    end
                end
            end
            PDTP_STREAM:
            begin
                // Stream prefetch answer refills the controller's stream line
                if (mem_valid)
                begin
                    s_d.strm_data = mem_data;
                    s_d.strm_vld  = 1'b1;
                    s_d.st        = PDTP_IDLE;
                end
            end
            default:
            begin
                s_d.st = PDTP_IDLE;
            end
        endcase

        // Channel switch with refetch set only records the left channel in fill_chan
        if (s_q.st == PDTP_ROUTE && !s_q.fill_pend && s_q.cur_vld &&
            s_q.cur_chan != chan && s_q.cur_vld && s_q.ctx[PDTP_CTX_REFETCH] &&
            chan < PDTP_RSVD_FIRST)
        begin
            s_d.fill_chan = s_q.cur_chan;
        end

        // Streaming buffer: one prefetch per consumed line while idle
        if (s_q.st == PDTP_IDLE && s_q.strm_pend && !build_we && !pci_req)
        begin
            s_d.mem_req   = 1'b1;
            s_d.mem_addr  = s_q.strm_addr;
            s_d.mem_sram  = 1'b0;
            s_d.strm_pend = 1'b0;
            s_d.st        = PDTP_STREAM;
        end
        // Builder write purges that channel's prefetched data; the purge wins
        if (build_we)
        begin
            s_d.pf_full[build_chan] = 1'b0;
            if (s_q.cur_vld && s_q.cur_chan == build_chan)
            begin
                s_d.strm_vld  = 1'b0;
                s_d.strm_pend = 1'b0;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s_q           <= '0;
            s_q.st        <= PDTP_IDLE;
            s_q.stall_ivl <= PDTP_STALL_IVL_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pci_valid = s_q.pci_valid;
    assign pci_data  = s_q.pci_data;
    assign pci_busy  = s_q.pci_busy;
    assign pci_nodma = s_q.pci_nodma;
    assign mem_req   = s_q.mem_req;
    assign mem_addr  = s_q.mem_addr;
    assign mem_sram  = s_q.mem_sram;
    assign pf_we     = s_q.pf_we;
    assign pf_addr   = s_q.pf_addr;
    assign pf_wdata  = s_q.pf_wdata;
    assign reg_rdata = s_q.reg_rdata;
endmodule : pdtp_core
`default_nettype wire

// File: verilog/pdtp_pkg.sv
// Package for the inbound PCI address translation and prefetch block.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package pdtp_pkg;
    // ****************************************************************
    // Address fields
    // ****************************************************************
    localparam int unsigned PDTP_PCI_AW     = 32;
    localparam int unsigned PDTP_SYS_AW     = 40;
    localparam int unsigned PDTP_CHAN_W     = 10;
    localparam int unsigned PDTP_OFS_W      = 22;
    localparam int unsigned PDTP_PBASE_W    = 18;
    localparam int unsigned PDTP_PG_OFS_W   = 12;
    localparam int unsigned PDTP_PG_NUM_W   = 10;
    localparam int unsigned PDTP_SPG_W      = 28;
    localparam int unsigned PDTP_LINE_W     = 64;
    localparam logic [9:0]  PDTP_RSVD_FIRST = 10'h3f0;
    localparam logic [9:0]  PDTP_SRAM_CHAN  = 10'h3ff;
    localparam logic [1:0]  PDTP_ENTRY_SHIFT_ZERO = 2'h0;
    // Line of 64 bits is eight bytes
    localparam logic [21:0] PDTP_LINE_BYTES = 22'h000008;

    // ****************************************************************
    // Context word layout: bit fields of one channel context entry, and the channel count
    // ****************************************************************
    localparam int unsigned PDTP_CTX_W      = 32;
    localparam int unsigned PDTP_CTX_XLATE  = 31;
    localparam int unsigned PDTP_CTX_PFEN   = 30;
    localparam int unsigned PDTP_CTX_REFETCH= 29;
    localparam int unsigned PDTP_CTX_BASE_LO= 0;
    localparam int unsigned PDTP_CHANS      = 1024;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] PDTP_REG_STALL_IVL = 8'h00;
    localparam logic [7:0] PDTP_REG_STATUS    = 8'h04;
    localparam logic [7:0] PDTP_REG_CUR_CHAN  = 8'h08;
    localparam logic [15:0] PDTP_STALL_IVL_RST = 16'h0010;

    typedef enum logic [2:0] {
        PDTP_IDLE   = 3'b000,
        PDTP_CTX    = 3'b001,
        PDTP_ROUTE  = 3'b011,
        PDTP_ENTRY  = 3'b010,
        PDTP_FETCH  = 3'b110,
        PDTP_STREAM = 3'b111,
        PDTP_BUILD  = 3'b101
    } pdtp_state_e;
endpackage : pdtp_pkg

// File: verilog/pdtp_ctx_if.sv
// Interface between the translator and its channel context memory.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pdtp_ctx_if;
    import pdtp_pkg::*;
    logic                   we;
    logic [PDTP_CHAN_W-1:0] addr;
    logic [PDTP_CTX_W-1:0]  wdata;
    logic [PDTP_CTX_W-1:0]  rdata;
    modport master (output we, output addr, output wdata, input rdata);
    modport mem    (input we, input addr, input wdata, output rdata);
endinterface : pdtp_ctx_if
`default_nettype wire

// File: verilog/pdtp_ctx_mem.sv
// Channel context memory, one word per logical channel, registered read.
// Assumes the translator drives one access per cycle.
`timescale 1ns/1ps
`default_nettype none
module pdtp_ctx_mem
    import pdtp_pkg::*;
(
    input  wire logic ref_clk,
    pdtp_ctx_if.mem   port
);
    logic [PDTP_CTX_W-1:0] mem_q [PDTP_CHANS];
    logic [PDTP_CTX_W-1:0] rd_q;

    // Read first, read data registered a cycle later
    always_ff @(posedge ref_clk)
    begin
        if (port.we)
        begin
            mem_q[port.addr] <= port.wdata;
        end
        rd_q <= mem_q[port.addr];
    end
    assign port.rdata = rd_q;
endmodule : pdtp_ctx_mem
`default_nettype wire

// File: sim/pdtp_core_sva.sv
// Assertions on the translator's PCI, memory and register ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pdtp_chk
    import pdtp_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        pci_req,
    input wire logic [31:0] pci_addr,
    input wire logic        pci_valid,
    input wire logic        pci_busy,
    input wire logic        pci_nodma,
    input wire logic        build_we,
    input wire logic [31:0] build_ctx,
    input wire logic        mem_req,
    input wire logic        mem_sram,
    input wire logic        pf_we,
    input wire logic        reg_re,
    input wire logic [31:0] reg_rdata
);
    logic       take;
    logic       rsv;
    logic [9:0] chan_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // A read is taken while busy is low; a build in the same cycle wins
    assign take = pci_req && !pci_busy && !build_we;
    assign rsv = take && pci_addr[31:22] >= PDTP_RSVD_FIRST && pci_addr[31:22] != PDTP_SRAM_CHAN;
    // Channel of the read in flight
    always_ff @(posedge ref_clk)
        if (take)
            chan_q <= pci_addr[31:22];
    chk_busy_take: assert property (take |=> pci_busy)
        else $error("busy not raised");
    chk_answer_late: assert property (take |=> !pci_valid [*3])
        else $error("read answered too early");
    chk_valid_pulse: assert property (pci_valid |=> !pci_valid)
        else $error("read data held too long");
    chk_valid_free: assert property (pci_valid |-> !pci_busy)
        else $error("busy held with answer");
    chk_sram_route: assert property (mem_req && pci_busy && chan_q == PDTP_SRAM_CHAN |-> mem_sram)
        else $error("top channel went to memory");
    chk_rsv_refuse: assert property (rsv |-> ##[1:6] (pci_nodma && !pci_busy))
        else $error("reserved channel not refused");
    chk_rsv_quiet: assert property (rsv |=> !(pci_valid || mem_req) [*8])
        else $error("reserved channel reached memory");
    chk_pf_fill: assert property (build_we && build_ctx[PDTP_CTX_PFEN] && !pci_busy |-> ##[1:40] pf_we)
        else $error("no channel prefetch after build");
    chk_reg_quiet: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    cov_read: cover property (take ##[4:40] pci_valid);
    cov_refuse: cover property ($rose(pci_nodma));
    cov_fill: cover property (pf_we);
endmodule : pdtp_chk
bind pdtp_core pdtp_chk i_pdtp_chk (.ref_clk, .rstn, .pci_req, .pci_addr, .pci_valid,
    .pci_busy, .pci_nodma, .build_we, .build_ctx, .mem_req, .mem_sram, .pf_we, .reg_re,
    .reg_rdata);
`default_nettype wire

// File: sim/pdtp_fabric_model.sv
// Memory fabric and channel prefetch SRAM seen from the translator.
// Assumes in-order answers; line data carries its own address.
`timescale 1ns/1ps
`default_nettype none
module pdtp_fabric_model
(
    input  wire logic        ref_clk,
    input  wire logic        mem_req,
    input  wire logic [39:0] mem_addr,
    output var  logic        mem_valid = 1'b0,
    output var  logic [63:0] mem_data = 64'h0,
    input  wire logic        pf_we,
    input  wire logic [9:0]  pf_addr,
    input  wire logic [63:0] pf_wdata,
    output var  logic [63:0] pf_rdata
);
    logic [39:0] addr_q[$];
    int          due_q[$];
    int          cyc = 0;
    logic [63:0] pf_mem [1024];
    // One answer per request, in order; address bit 3 picks a slow answer
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (mem_req)
        begin
            addr_q.push_back(mem_addr);
            due_q.push_back(cyc + (mem_addr[3] ? 12 : 1));
        end
        if (due_q.size() > 0 && due_q[0] <= cyc)
        begin
            mem_valid <= 1'b1;
            mem_data <= {24'h5a5a5a, addr_q.pop_front()}; // Fixed tag plus the request address
            void'(due_q.pop_front());
        end
        else
        begin
            mem_valid <= 1'b0;
            mem_data <= ~mem_data; // Never leaves the last line standing
        end
    end
    // Registered SRAM read, one line per channel
    always @(posedge ref_clk)
    begin
        if (pf_we)
            pf_mem[pf_addr] <= pf_wdata;
        pf_rdata <= pf_mem[pf_addr];
    end
endmodule : pdtp_fabric_model
`default_nettype wire

// File: sim/pdtp_core_tb.sv
// Bench for the PCI translation and prefetch core.
// Assumes the fabric model returns each line as a tag plus its address.
`timescale 1ns/1ps
`default_nettype none
module pdtp_core_tb;
    import pdtp_pkg::*;
    logic        ref_clk, rstn = 1'b0, pci_req = 1'b0, build_we = 1'b0, saw_sram = 1'b0;
    logic        reg_we = 1'b0, reg_re = 1'b0, pci_valid, pci_busy, pci_nodma;
    logic        mem_req, mem_sram, mem_valid, pf_we;
    logic [31:0] pci_addr = '0, build_ctx = '0, reg_wdata = '0, reg_rdata;
    logic [9:0]  build_chan = '0, pf_addr;
    logic [7:0]  reg_addr = '0;
    logic [39:0] mem_addr;
    logic [63:0] pci_data, mem_data, pf_wdata, pf_rdata, d;
    logic [1:0]  st;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    pdtp_core i_pdtp_core (.ref_clk, .rstn, .pci_req, .pci_addr, .pci_valid, .pci_data,
        .pci_busy, .pci_nodma, .build_we, .build_chan, .build_ctx, .mem_req, .mem_addr,
        .mem_sram, .mem_valid, .mem_data, .pf_we, .pf_addr, .pf_wdata, .pf_rdata,
        .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
    pdtp_fabric_model i_pdtp_fabric_model (.ref_clk, .mem_req, .mem_addr, .mem_valid,
        .mem_data, .pf_we, .pf_addr, .pf_wdata, .pf_rdata);
    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard at 5000 cycles, well past the few hundred cycles the tests need
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (mem_req && mem_sram)
            saw_sram <= 1'b1;
        if (cycles == 5000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1;
        check(reg_rdata, e);
        @(posedge ref_clk);
    endtask : reg_rd
    task automatic build(input logic [9:0] c, input logic [31:0] x);
        build_we <= 1'b1;
        build_chan <= c;
        build_ctx <= x;
        @(posedge ref_clk);
        build_we <= 1'b0;
        repeat (40) @(posedge ref_clk); // Room for a slow prefetch fill
    endtask : build
    // Read one line; st holds valid and refusal as the busy flag drops
    task automatic pci_rd(input logic [31:0] a);
        int n = 0;
        pci_req <= 1'b1;
        pci_addr <= a;
        @(posedge ref_clk);
        pci_req <= 1'b0;
        #1;
        while (pci_busy === 1'b1 && n < 300)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        d = pci_data;
        st = {pci_valid, pci_nodma};
        repeat (40) @(posedge ref_clk); // Stream prefetch and reissues drain
    endtask : pci_rd
    task automatic t_regs();
        reg_rd(PDTP_REG_STALL_IVL, {16'h0, PDTP_STALL_IVL_RST});
        reg_addr <= PDTP_REG_STALL_IVL;
        reg_wdata <= 32'h3;
        reg_we <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
        reg_rd(PDTP_REG_STALL_IVL, 32'h3);
        reg_rd(8'hfc, 32'h0);
    endtask : t_regs
    task automatic t_phys();
        build(10'd5, {14'h0, 18'h2abcd});
        pci_rd({10'd5, 22'h123458});
        check(st, 2'b10);
        check(d, {24'h5a5a5a, 18'h2abcd, 22'h123458});
    endtask : t_phys
    task automatic t_table();
        build(10'd7, {4'h8, 28'h0012345});
        pci_rd({10'd7, 10'h2a3, 12'h5a0});
        check(st, 2'b10);
        check(d, {24'h5a5a5a, 16'h2345, 10'h2a3, 2'b00, 12'h5a0});
    endtask : t_table
    task automatic t_sram();
        build(10'h3ff, 32'h0);
        pci_rd({10'h3ff, 22'h000100});
        check(st, 2'b10);
        check(saw_sram, 1'b1);
        check(d, {24'h5a5a5a, 18'h0, 22'h000100});
    endtask : t_sram
    // Start-up fill, then a rebuild must drop the old line
    task automatic t_pf();
        build(10'd9, {14'h1000, 18'h1c0de});
        pci_rd({10'd9, 22'h0});
        check(d, {24'h5a5a5a, 18'h1c0de, 22'h0});
        build(10'd9, {14'h1000, 18'h0beef});
        pci_rd({10'd9, 22'h0});
        check(d, {24'h5a5a5a, 18'h0beef, 22'h0});
        reg_rd(PDTP_REG_CUR_CHAN, 32'h9);
    endtask : t_pf
    task automatic t_rsv();
        for (int i = 0; i < 3; i++)
        begin
            pci_rd({10'd1008 + 10'(7 * i), 22'h0});
            check(st, 2'b01);
        end
        repeat (10) @(posedge ref_clk);
    endtask : t_rsv
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_phys();
        t_table();
        t_sram();
        t_pf();
        t_rsv();
        complete_run();
    end
endmodule : pdtp_core_tb
`default_nettype wire
